// ---- inc/pwr_ctl_pkg.sv ----
/*
  Constants for the remote power and reset control block.
  Assumes a 40 MHz standby-powered logic clock.
*/
package pwr_ctl_pkg;
    // ------------------------------------------------------------
    // Clock and timing
    // ------------------------------------------------------------
    localparam int unsigned CLK_HZ         = 40_000_000;
    localparam int unsigned DEBOUNCE_US    = 10_000;
    localparam int unsigned DEBOUNCE_CYC   = (CLK_HZ / 1_000_000) * DEBOUNCE_US;
    localparam int unsigned SYNC_STAGES    = 3;

    // ------------------------------------------------------------
    // Register map (AXI4-Lite byte offsets)
    // ------------------------------------------------------------
    localparam logic [3:0] CTRL_OFS   = 4'h0;
    localparam logic [3:0] STAT_OFS   = 4'h4;
    localparam logic [3:0] EVENT_OFS  = 4'h8;
    localparam logic [3:0] MASK_OFS   = 4'hc;

    // Control register fields.
    localparam int CTRL_REMOTE_BIT = 0;
    localparam logic [31:0] CTRL_RESET = 32'h0000_0000;

    // Event bits: toggle press, reset press, supply-good rise, supply-good fall.
    localparam int EV_TOGGLE  = 0;
    localparam int EV_RSTBTN  = 1;
    localparam int EV_PGRISE  = 2;
    localparam int EV_PGFALL  = 3;
    localparam int EV_W       = 4;
    localparam logic [EV_W-1:0] MASK_RESET = 4'h0;

    // AXI responses.
    localparam logic [1:0] RESP_OKAY   = 2'b00;
    localparam logic [1:0] RESP_SLVERR = 2'b10;

    // Supply control levels: high means supply off.
    localparam logic SUPPLY_OFF = 1'b1;

    typedef enum logic [0:0] {
        PS_STANDBY = 1'b0,
        PS_RUN     = 1'b1
    } pwr_state_t;
endpackage

// ---- inc/btn_if.sv ----
/*
  Carrier between the top and the input conditioner.
  Assumes one clock domain.
*/
`timescale 1ns/1ps
interface btn_if;
    logic raw_n;
    logic level;
    logic press;
    modport cond (input raw_n, output level, output press);
    modport user (output raw_n, input level, input press);
endinterface // btn_if

// ---- src/btn_cond.sv ----
/*
  Synchroniser and debouncer for one active-low pin input.
  Assumes the pin is asynchronous to mclk_i; one press yields one pulse.
*/
`timescale 1ns/1ps
module btn_cond
    import pwr_ctl_pkg::*;
#(
    parameter int unsigned DEB_CYC = pwr_ctl_pkg::DEBOUNCE_CYC
) (
    // Clock and reset
    input  wire logic mclk_i,
    input  wire logic rst_i,
    // Conditioned signals
    btn_if.cond       pin
);
    import pwr_ctl_pkg::*;

    logic [2:0]  sync;
    logic [31:0] cnt;
    logic        stable_n;

    // Three stages; only the second and third are compared.
    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            sync <= 3'h7;
        end else begin
            sync <= {sync[1:0], pin.raw_n};
        end
    end

    // Accept a new level only after it holds for the whole debounce time.
    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            cnt      <= 32'h0;
            stable_n <= 1'b1;
            pin.press <= 1'b0;
        end else begin
            pin.press <= 1'b0;
            if ((sync[1] == sync[2]) && (sync[2] != stable_n)) begin
                if (cnt >= DEB_CYC - 1) begin
                    cnt      <= 32'h0;
                    stable_n <= sync[2];
                    pin.press <= ~sync[2];
                end else begin
                    cnt <= cnt + 32'h1;
                end
            end else begin
                cnt <= 32'h0;
            end
        end
    end

    assign pin.level = ~stable_n;
endmodule // btn_cond

// ---- src/remote_power_reset_control.sv ----
/*
  Remote-mode power and reset control with an AXI4-Lite register slave.
  Assumes a 40 MHz standby clock; pins are split into in/out/enable.
*/
// Notes on behaviour
// - In remote mode each toggle button press flips supply control on/off.
// - Sleep indicator is high in standby, low otherwise, in remote mode.
// - Run indicator is high while switched on, low otherwise, in remote mode.
// - Reset-done indicator is low once all resets are released, high otherwise.
// - Slot reset asserts on upstream reset, reset button low, or supply-good low.
// - In host mode every dual-function output is undriven.
// - In host mode the toggle and reset button inputs are ignored.
// - Mode selects upstream role in host, downstream in remote, enabling pins.
// - Supply control comes up high (off); low requests supply on.
// - Reset button resets the device itself as well as the slot.
// - Supply-good and supply-fault indicators are active low, per supply-good.
`timescale 1ns/1ps
module remote_power_reset_control
    import pwr_ctl_pkg::*;
#(
    parameter int unsigned DEB_CYC = pwr_ctl_pkg::DEBOUNCE_CYC
) (
    // Clock and reset
    input  wire logic        mclk_i,
    input  wire logic        rst_i,
    // AXI4-Lite write channels
    input  wire logic [3:0]  s_awaddr_i,
    input  wire logic        s_awvalid_i,
    output logic             s_awready_o,
    input  wire logic [31:0] s_wdata_i,
    input  wire logic [3:0]  s_wstrb_i,
    input  wire logic        s_wvalid_i,
    output logic             s_wready_o,
    output logic [1:0]       s_bresp_o,
    output logic             s_bvalid_o,
    input  wire logic        s_bready_i,
    // AXI4-Lite read channels
    input  wire logic [3:0]  s_araddr_i,
    input  wire logic        s_arvalid_i,
    output logic             s_arready_o,
    output logic [31:0]      s_rdata_o,
    output logic [1:0]       s_rresp_o,
    output logic             s_rvalid_o,
    input  wire logic        s_rready_i,
    // Pin inputs
    input  wire logic        toggle_btn_n_i,
    input  wire logic        reset_btn_n_i,
    input  wire logic        psu_good_signal_i,
    input  wire logic        upstream_rst_n_i,
    // Dual-function outputs
    output logic             sleep_indicator_o,
    output logic             run_indicator_o,
    output logic             reset_done_indicator_o,
    output logic             supply_good_indicator_o,
    output logic             supply_fault_indicator_o,
    output logic             slot_rst_n_o,
    output logic             supply_ctrl_o,
    output logic             pins_oe_o,
    // Link role and interrupt
    output logic             downstream_role_o,
    output logic             self_rst_o,
    output logic             irq_o
);
    import pwr_ctl_pkg::*;

    // ------------------------------------------------------------
    // Input conditioning
    // ------------------------------------------------------------
    btn_if tog_c ();
    btn_if rst_c ();
    assign tog_c.raw_n = toggle_btn_n_i;
    assign rst_c.raw_n = reset_btn_n_i;

    btn_cond #(.DEB_CYC(DEB_CYC)) u_tog (
        .mclk_i (mclk_i),
        .rst_i  (rst_i),
        .pin    (tog_c)
    );
    btn_cond #(.DEB_CYC(DEB_CYC)) u_rst (
        .mclk_i (mclk_i),
        .rst_i  (rst_i),
        .pin    (rst_c)
    );

    // Supply-good and upstream reset pass three stages; change on agreement.
    logic [2:0] pg_sync;
    logic [2:0] up_sync;
    logic       pg;
    logic       up_rst_n;
    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            pg_sync  <= 3'h0;
            up_sync  <= 3'h0;
            pg       <= 1'b0;
            up_rst_n <= 1'b0;
        end else begin
            pg_sync <= {pg_sync[1:0], psu_good_signal_i};
            up_sync <= {up_sync[1:0], upstream_rst_n_i};
            if (pg_sync[1] == pg_sync[2]) begin
                pg <= pg_sync[2];
            end
            if (up_sync[1] == up_sync[2]) begin
                up_rst_n <= up_sync[2];
            end
        end
    end

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    logic [31:0]     ctrl;
    logic [EV_W-1:0] events;
    logic [EV_W-1:0] mask;
    logic            remote;
    pwr_state_t      pstate;
    logic            pg_q;
    assign remote = ctrl[CTRL_REMOTE_BIT];

    // Power state: button presses count only in remote mode.
    // The local reset button does not touch the power state, so a user can
    // restart the card without dropping the supply.
    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            pstate <= PS_STANDBY;
        end else if (remote && tog_c.press) begin
            pstate <= (pstate == PS_RUN) ? PS_STANDBY : PS_RUN;
        end
    end

    // Event capture; a set in the same cycle as a read-clear wins.
    logic [EV_W-1:0] ev_now;
    logic            ev_rd;
    always_comb begin
        ev_now = '0;
        ev_now[EV_TOGGLE] = remote & tog_c.press;
        ev_now[EV_RSTBTN] = remote & rst_c.press;
        ev_now[EV_PGRISE] = pg & ~pg_q;
        ev_now[EV_PGFALL] = ~pg & pg_q;
    end

    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            events <= '0;
            pg_q   <= 1'b0;
        end else begin
            pg_q   <= pg;
            events <= (ev_rd ? '0 : events) | ev_now;
        end
    end

    // ------------------------------------------------------------
    // Output drive
    // ------------------------------------------------------------
    logic rst_req;
    assign rst_req = ~up_rst_n | (remote & rst_c.level) | ~pg;

    // All pin outputs registered; in host mode enable drops and levels park.
    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            sleep_indicator_o        <= 1'b0;
            run_indicator_o          <= 1'b0;
            reset_done_indicator_o   <= 1'b1;
            supply_good_indicator_o  <= 1'b1;
            supply_fault_indicator_o <= 1'b1;
            slot_rst_n_o             <= 1'b0;
            supply_ctrl_o            <= SUPPLY_OFF;
            pins_oe_o                <= 1'b0;
            downstream_role_o        <= 1'b0;
            self_rst_o               <= 1'b0;
            irq_o                    <= 1'b0;
        end else begin
            pins_oe_o                <= remote;
            downstream_role_o        <= remote;
            sleep_indicator_o        <= remote & (pstate == PS_STANDBY);
            run_indicator_o          <= remote & (pstate == PS_RUN);
            supply_ctrl_o            <= ~(remote & (pstate == PS_RUN));
            supply_good_indicator_o  <= ~(remote & pg);
            supply_fault_indicator_o <= ~(remote & ~pg);
            slot_rst_n_o             <= ~(remote & rst_req);
            reset_done_indicator_o   <= remote & rst_req;
            self_rst_o               <= remote & rst_c.level;
            irq_o                    <= |(events & mask);
        end
    end

    // ------------------------------------------------------------
    // AXI4-Lite write
    // ------------------------------------------------------------
    logic [3:0]  aw_addr;
    logic        aw_have;
    logic [31:0] w_data;
    logic [3:0]  w_strb;
    logic        w_have;
    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            aw_have     <= 1'b0;
            w_have      <= 1'b0;
            aw_addr     <= 4'h0;
            w_data      <= 32'h0;
            w_strb      <= 4'h0;
            s_awready_o <= 1'b1;
            s_wready_o  <= 1'b1;
            s_bvalid_o  <= 1'b0;
            s_bresp_o   <= RESP_OKAY;
            ctrl        <= CTRL_RESET;
            mask        <= MASK_RESET;
        end else begin
            if (s_awvalid_i && s_awready_o) begin
                aw_addr     <= s_awaddr_i;
                aw_have     <= 1'b1;
                s_awready_o <= 1'b0;
            end
            if (s_wvalid_i && s_wready_o) begin
                w_data     <= s_wdata_i;
                w_strb     <= s_wstrb_i;
                w_have     <= 1'b1;
                s_wready_o <= 1'b0;
            end
            if (aw_have && w_have && !s_bvalid_o) begin
                s_bvalid_o <= 1'b1;
                s_bresp_o  <= RESP_OKAY;
                case (aw_addr)
                    CTRL_OFS: begin
                        if (w_strb[0]) ctrl[7:0] <= w_data[7:0];
                    end
                    MASK_OFS: begin
                        if (w_strb[0]) mask <= w_data[EV_W-1:0];
                    end
                    STAT_OFS, EVENT_OFS: begin
                        s_bresp_o <= RESP_OKAY;
                    end
                    default: begin
                        s_bresp_o <= RESP_SLVERR;
                    end
                endcase
            end
            if (s_bvalid_o && s_bready_i) begin
                s_bvalid_o  <= 1'b0;
                aw_have     <= 1'b0;
                w_have      <= 1'b0;
                s_awready_o <= 1'b1;
                s_wready_o  <= 1'b1;
            end
        end
    end

    // ------------------------------------------------------------
    // AXI4-Lite read
    // ------------------------------------------------------------
    logic [31:0] stat_word;
    always_comb begin
        stat_word    = 32'h0;
        stat_word[0] = (pstate == PS_RUN);
        stat_word[1] = pg;
        stat_word[2] = up_rst_n;
        stat_word[3] = rst_c.level;
        stat_word[4] = rst_req;
    end

    assign ev_rd = s_arvalid_i && s_arready_o && (s_araddr_i == EVENT_OFS);

    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            s_arready_o <= 1'b1;
            s_rvalid_o  <= 1'b0;
            s_rdata_o   <= 32'h0;
            s_rresp_o   <= RESP_OKAY;
        end else begin
            if (s_arvalid_i && s_arready_o) begin
                s_arready_o <= 1'b0;
                s_rvalid_o  <= 1'b1;
                s_rresp_o   <= RESP_OKAY;
                case (s_araddr_i)
                    CTRL_OFS:  s_rdata_o <= ctrl;
                    STAT_OFS:  s_rdata_o <= stat_word;
                    EVENT_OFS: s_rdata_o <= {28'h0, events};
                    MASK_OFS:  s_rdata_o <= {28'h0, mask};
                    default: begin
                        s_rdata_o <= 32'h0;
                        s_rresp_o <= RESP_SLVERR;
                    end
                endcase
            end else if (s_rvalid_o && s_rready_i) begin
                s_rvalid_o  <= 1'b0;
                s_arready_o <= 1'b1;
            end
        end
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    sequence press_s;
        remote && tog_c.press;
    endsequence

    host_quiet_a: assert property (@(posedge mclk_i) disable iff (rst_i)
        !remote |=> !pins_oe_o && !downstream_role_o)
        else $error("outputs enabled in host mode");
    toggle_flip_a: assert property (@(posedge mclk_i) disable iff (rst_i)
        press_s |=> pstate != $past(pstate))
        else $error("press did not flip power state");
    host_ignore_a: assert property (@(posedge mclk_i) disable iff (rst_i)
        !remote |=> $stable(pstate))
        else $error("power state moved in host mode");
    sleep_led_a: assert property (@(posedge mclk_i) disable iff (rst_i)
        remote && pstate == PS_STANDBY |=> sleep_indicator_o && !run_indicator_o)
        else $error("sleep indicator wrong");
    run_led_a: assert property (@(posedge mclk_i) disable iff (rst_i)
        remote && pstate == PS_RUN |=> run_indicator_o && !supply_ctrl_o)
        else $error("run indicator or supply control wrong");
    slot_rst_a: assert property (@(posedge mclk_i) disable iff (rst_i)
        remote && !pg |=> !slot_rst_n_o && reset_done_indicator_o)
        else $error("slot reset not asserted on supply fault");
    rst_done_a: assert property (@(posedge mclk_i) disable iff (rst_i)
        remote && !rst_req |=> slot_rst_n_o && !reset_done_indicator_o)
        else $error("reset done indicator wrong");
    pg_leds_a: assert property (@(posedge mclk_i) disable iff (rst_i)
        remote |=> supply_good_indicator_o != supply_fault_indicator_o)
        else $error("supply indicators not exclusive");
    self_rst_a: assert property (@(posedge mclk_i) disable iff (rst_i)
        remote && rst_c.level |=> self_rst_o && !slot_rst_n_o)
        else $error("reset button did not reset");
endmodule // remote_power_reset_control

// ---- tb/psu_model.sv ----
/*
  Behavioural computer supply with its voltage supervisor.
  Assumes supply_ctrl_i low requests the rails on; fail_i forces a rail fault.
*/
`timescale 1ns/1ps
module psu_model #(
    parameter int ON_DLY = 8,
    parameter bit NO_PG  = 1'b0
) (
    // Clock and controls
    input  wire logic mclk_i,
    input  wire logic supply_ctrl_i,
    input  wire logic fail_i,
    // Supervisor output
    output logic      psu_good_signal_o
);
    int on_cnt = 0;

    // ------------------------------------------------------------
    // Rails
    // ------------------------------------------------------------
    // Rails ramp for some cycles, so good never follows the request at once.
    always @(posedge mclk_i) begin
        if (supply_ctrl_i || fail_i) begin
            on_cnt <= 0;
        end else if (on_cnt < ON_DLY) begin
            on_cnt <= on_cnt + 1;
        end
    end

    // Good only while both rails are up; a board without supervisor ties it high.
    assign psu_good_signal_o = NO_PG ? 1'b1 : (on_cnt == ON_DLY);
endmodule // psu_model

// ---- tb/testbench.sv ----
/*
  Self-checking bench for the remote power and reset control block.
  Assumes psu_model stands for the supply and the bench for buttons and host.
*/
`timescale 1ns/1ps
module testbench;
    import pwr_ctl_pkg::*;
    logic        mclk_i = 1'b0;
    logic        rst_i = 1'b1;
    logic [3:0]  s_awaddr_i = 4'h0, s_araddr_i = 4'h0, s_wstrb_i = 4'h0;
    logic        s_awvalid_i = 1'b0, s_wvalid_i = 1'b0, s_bready_i = 1'b0;
    logic        s_arvalid_i = 1'b0, s_rready_i = 1'b0;
    logic [31:0] s_wdata_i = 32'h0, s_rdata_o, rcap, rd;
    logic [1:0]  s_bresp_o, s_rresp_o, bcap, rrcap, rsp;
    logic        s_awready_o, s_wready_o, s_bvalid_o, s_arready_o, s_rvalid_o;
    logic        aw_hs, w_hs, b_hs, ar_hs, r_hs;
    logic [1:0]  btn_n = 2'h3;
    logic        upstream_rst_n_i = 1'b1, fail = 1'b0, psu_good_signal_i;
    logic        sleep_indicator_o, run_indicator_o, reset_done_indicator_o;
    logic        supply_good_indicator_o, supply_fault_indicator_o, slot_rst_n_o;
    logic        supply_ctrl_o, pins_oe_o, downstream_role_o, self_rst_o, irq_o;
    int          error_cnt = 0;
    int          comparisons = 0;

    // The clock runs at 40 MHz.
    always #12.5 mclk_i = ~mclk_i;

    // ------------------------------------------------------------
    // Instances
    // ------------------------------------------------------------
    remote_power_reset_control #(.DEB_CYC(4)) i_dut (
        .mclk_i, .rst_i, .s_awaddr_i, .s_awvalid_i, .s_awready_o, .s_wdata_i, .s_wstrb_i,
        .s_wvalid_i, .s_wready_o, .s_bresp_o, .s_bvalid_o, .s_bready_i, .s_araddr_i,
        .s_arvalid_i, .s_arready_o, .s_rdata_o, .s_rresp_o, .s_rvalid_o, .s_rready_i,
        .toggle_btn_n_i(btn_n[0]), .reset_btn_n_i(btn_n[1]), .psu_good_signal_i,
        .upstream_rst_n_i, .sleep_indicator_o, .run_indicator_o, .reset_done_indicator_o,
        .supply_good_indicator_o, .supply_fault_indicator_o, .slot_rst_n_o, .supply_ctrl_o,
        .pins_oe_o, .downstream_role_o, .self_rst_o, .irq_o
    );
    psu_model #(.ON_DLY(8), .NO_PG(1'b0)) i_psu (
        .mclk_i, .supply_ctrl_i(supply_ctrl_o), .fail_i(fail),
        .psu_good_signal_o(psu_good_signal_i)
    );

    // Handshakes and answers are caught at the edge itself, free of races.
    always @(posedge mclk_i) begin
        aw_hs <= s_awvalid_i & s_awready_o;
        w_hs  <= s_wvalid_i & s_wready_o;
        b_hs  <= s_bvalid_o & s_bready_i;
        ar_hs <= s_arvalid_i & s_arready_o;
        r_hs  <= s_rvalid_o & s_rready_i;
        if (s_bvalid_o & s_bready_i) bcap <= s_bresp_o;
        if (s_rvalid_o & s_rready_i) rcap <= s_rdata_o;
        if (s_rvalid_o & s_rready_i) rrcap <= s_rresp_o;
    end

    // ------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------
    task automatic tick;
        @(posedge mclk_i);
        #1;
    endtask

    // Waits on the answer alone; only the watchdog may end a hung transfer.
    task automatic axi_wr(input logic [3:0] a, input logic [31:0] d, output logic [1:0] r);
        tick;
        s_awaddr_i <= a;
        s_awvalid_i <= 1'b1;
        s_wdata_i <= d;
        s_wstrb_i <= 4'hf;
        s_wvalid_i <= 1'b1;
        s_bready_i <= 1'b1;
        do begin
            tick;
            if (aw_hs) s_awvalid_i <= 1'b0;
            if (w_hs) s_wvalid_i <= 1'b0;
        end while (!b_hs);
        s_bready_i <= 1'b0;
        r = bcap;
    endtask

    task automatic axi_rd(input logic [3:0] a, output logic [31:0] d, output logic [1:0] r);
        tick;
        s_araddr_i <= a;
        s_arvalid_i <= 1'b1;
        s_rready_i <= 1'b1;
        do begin
            tick;
            if (ar_hs) s_arvalid_i <= 1'b0;
        end while (!r_hs);
        s_rready_i <= 1'b0;
        d = rcap;
        r = rrcap;
    endtask

    task automatic chk_b(input string what, input logic e, input logic g);
        comparisons++;
        if (g !== e) begin
            error_cnt++;
            $display("[FAIL] %s expected %b seen %b", what, e, g);
        end
    endtask

    task automatic chk_w(input string what, input logic [31:0] e, input logic [31:0] g);
        comparisons++;
        if (g !== e) begin
            error_cnt++;
            $display("[FAIL] %s expected %h seen %h", what, e, g);
        end
    endtask

    // A press is held well past the sync and debounce time, then released as long.
    task automatic press(input int k);
        tick;
        btn_n[k] <= 1'b0;
        repeat (20) tick;
        btn_n[k] <= 1'b1;
        repeat (20) tick;
    endtask

    task automatic test_end(input string name);
        $display("test %s finished", name);
    endtask

    task automatic end_of_test;
        $display("comparisons %0d mismatches %0d", comparisons, error_cnt);
        if (error_cnt == 0 && comparisons > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    // ------------------------------------------------------------
    // Tests
    // ------------------------------------------------------------
    // Reset, host mode, remote power on, reset sources, power off, host again.
    initial begin
        repeat (12) @(posedge mclk_i);
        rst_i <= 1'b0;
        tick;
        chk_b("supply_ctrl", SUPPLY_OFF, supply_ctrl_o);
        chk_b("role", 1'b0, downstream_role_o);
        press(0);
        chk_b("supply_ctrl", SUPPLY_OFF, supply_ctrl_o);
        chk_b("pins_oe", 1'b0, pins_oe_o);
        axi_wr(4'h6, 32'h1, rsp);
        chk_w("unmapped wr resp", {30'h0, RESP_SLVERR}, {30'h0, rsp});
        axi_rd(CTRL_OFS, rd, rsp);
        chk_w("ctrl", CTRL_RESET, rd);
        axi_rd(4'h6, rd, rsp);
        chk_w("unmapped resp", {30'h0, RESP_SLVERR}, {30'h0, rsp});
        test_end("host");
        axi_wr(CTRL_OFS, 32'h1, rsp);
        chk_w("ctrl wr resp", {30'h0, RESP_OKAY}, {30'h0, rsp});
        repeat (4) tick;
        chk_b("pins_oe", 1'b1, pins_oe_o);
        chk_b("role", 1'b1, downstream_role_o);
        chk_b("sleep", 1'b1, sleep_indicator_o);
        chk_b("run", 1'b0, run_indicator_o);
        chk_b("slot_rst_n", 1'b0, slot_rst_n_o);
        chk_b("fault_ind", 1'b0, supply_fault_indicator_o);
        chk_b("reset_done", 1'b1, reset_done_indicator_o);
        axi_rd(EVENT_OFS, rd, rsp);
        axi_wr(MASK_OFS, 32'h1, rsp);
        axi_rd(MASK_OFS, rd, rsp);
        chk_w("mask", 32'h1, rd);
        chk_w("mask rd resp", {30'h0, RESP_OKAY}, {30'h0, rsp});
        press(0);
        chk_b("supply_ctrl", 1'b0, supply_ctrl_o);
        chk_b("run", 1'b1, run_indicator_o);
        chk_b("sleep", 1'b0, sleep_indicator_o);
        chk_b("good_ind", 1'b0, supply_good_indicator_o);
        chk_b("slot_rst_n", 1'b1, slot_rst_n_o);
        chk_b("reset_done", 1'b0, reset_done_indicator_o);
        chk_b("irq", 1'b1, irq_o);
        axi_rd(STAT_OFS, rd, rsp);
        chk_w("stat", 32'h7, rd);
        axi_rd(EVENT_OFS, rd, rsp);
        chk_w("event", 32'h5, rd);
        repeat (2) tick;
        chk_b("irq", 1'b0, irq_o);
        test_end("power on");
        upstream_rst_n_i <= 1'b0;
        repeat (8) tick;
        chk_b("slot_rst_n", 1'b0, slot_rst_n_o);
        chk_b("reset_done", 1'b1, reset_done_indicator_o);
        upstream_rst_n_i <= 1'b1;
        repeat (8) tick;
        btn_n[1] <= 1'b0;
        repeat (20) tick;
        chk_b("self_rst", 1'b1, self_rst_o);
        chk_b("slot_rst_n", 1'b0, slot_rst_n_o);
        btn_n[1] <= 1'b1;
        repeat (20) tick;
        chk_b("self_rst", 1'b0, self_rst_o);
        chk_b("slot_rst_n", 1'b1, slot_rst_n_o);
        fail <= 1'b1;
        repeat (8) tick;
        chk_b("slot_rst_n", 1'b0, slot_rst_n_o);
        chk_b("fault_ind", 1'b0, supply_fault_indicator_o);
        fail <= 1'b0;
        repeat (24) tick;
        axi_rd(EVENT_OFS, rd, rsp);
        chk_w("event", 32'he, rd);
        test_end("resets");
        // A bounce shorter than the debounce time must leave the supply alone.
        btn_n[0] <= 1'b0;
        repeat (2) tick;
        btn_n[0] <= 1'b1;
        repeat (20) tick;
        chk_b("supply_ctrl", 1'b0, supply_ctrl_o);
        press(0);
        chk_b("supply_ctrl", SUPPLY_OFF, supply_ctrl_o);
        chk_b("sleep", 1'b1, sleep_indicator_o);
        axi_rd(EVENT_OFS, rd, rsp);
        chk_w("event", 32'h9, rd);
        axi_wr(CTRL_OFS, 32'h0, rsp);
        repeat (4) tick;
        chk_b("pins_oe", 1'b0, pins_oe_o);
        chk_b("role", 1'b0, downstream_role_o);
        test_end("power off");
        end_of_test;
    end

    // The tests take under a thousand cycles; a hang is cut off well beyond.
    initial begin
        repeat (5000) @(posedge mclk_i);
        error_cnt++;
        end_of_test;
    end
endmodule // testbench
